/* hw/stx_lane_regs.sv */
// stx_lane_regs.sv
// lane_tx_ctrl_a and lane_tx_ctrl_b storage of one lane
// assumes write enables already decoded by the quad logic
`timescale 1ns/1ns
`include "stx_cfg.svh"

module stx_lane_regs (
	// clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_b_i,
	// writes
	input  wire logic        we_a_i,
	input  wire logic        we_b_i,
	input  wire logic [31:0] wdata_i,
	// stored words
	output logic      [31:0] ctrl_a_o,
	output logic      [31:0] ctrl_b_o
);

	// ----------------------------------------
	// storage
	// ----------------------------------------

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_a_o <= `STX_RST_A;
		end else if (we_a_i) begin
			// reserved bits kept at zero
			ctrl_a_o <= wdata_i & `STX_MASK_A;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_b_o <= `STX_RST_B;
		end else if (we_b_i) begin
			ctrl_b_o <= wdata_i;
		end
	end

endmodule : stx_lane_regs

/* hw/stx_mode_mux.sv */
// stx_mode_mux.sv
// picks one lane's field set for the current phy mode, registered
// assumes mode and margin come from logic on the same clock
`timescale 1ns/1ns
`include "stx_cfg.svh"

module stx_mode_mux (
	// clock and reset
	input  wire logic                core_clk_i,
	input  wire logic                rst_b_i,
	// lane words and quad state
	input  wire logic         [31:0] ctrl_a_i,
	input  wire logic         [31:0] ctrl_b_i,
	input  wire stx_pkg::stx_mode_e  mode_i,
	input  wire logic          [2:0] tm_i,
	// applied settings
	output stx_pkg::stx_drive_s      drive_o
);

	stx_pkg::stx_drive_s drive_d;  // next settings

	// ----------------------------------------
	// field selection
	// ----------------------------------------

	// per-mode field picking, margin beside
	always_comb begin
		drive_d = '0;
		drive_d.margin_on = (tm_i != `STX_TM_NORMAL);
		drive_d.margin    = tm_i;
		unique case (mode_i)
			stx_pkg::MODE_FS35_R1: begin
				drive_d.cdeemph = ctrl_a_i[`STX_A_CD35R1];
				drive_d.txeq    = ctrl_a_i[`STX_A_EQ35R1];
				drive_d.cslew   = ctrl_a_i[`STX_A_CSLEW1];
				drive_d.fslew   = ctrl_a_i[`STX_A_FSLEW1];
				drive_d.drive   = ctrl_b_i[`STX_B_DL35R1];
				drive_d.fdeemph = ctrl_b_i[`STX_B_FD35R1];
			end
			stx_pkg::MODE_FS35_R2: begin
				drive_d.cdeemph = ctrl_a_i[`STX_A_CD35R2];
				drive_d.txeq    = ctrl_a_i[`STX_A_EQ35R2];
				drive_d.cslew   = ctrl_a_i[`STX_A_CSLEW2];
				drive_d.fslew   = ctrl_a_i[`STX_A_FSLEW2];
				drive_d.drive   = ctrl_b_i[`STX_B_DL35R2];
				drive_d.fdeemph = ctrl_b_i[`STX_B_FD35R2];
			end
			stx_pkg::MODE_FS60_R2: begin
				drive_d.cdeemph = ctrl_a_i[`STX_A_CD60R2];
				drive_d.txeq    = ctrl_a_i[`STX_A_EQ60R2];
				drive_d.cslew   = ctrl_a_i[`STX_A_CSLEW2];
				drive_d.fslew   = ctrl_a_i[`STX_A_FSLEW2];
				drive_d.drive   = ctrl_b_i[`STX_B_DL60R2];
				drive_d.fdeemph = ctrl_b_i[`STX_B_FD60R2];
			end
			stx_pkg::MODE_LS_R1: begin
				drive_d.cslew      = ctrl_a_i[`STX_A_CSLEW1];
				drive_d.fslew      = ctrl_a_i[`STX_A_FSLEW1];
				drive_d.drive      = {1'b0, ctrl_b_i[`STX_B_DLLSR1]};
				drive_d.deemph_off = 1'b1;
			end
			stx_pkg::MODE_LS_R2: begin
				drive_d.cslew      = ctrl_a_i[`STX_A_CSLEW2];
				drive_d.fslew      = ctrl_a_i[`STX_A_FSLEW2];
				drive_d.drive      = {1'b0, ctrl_b_i[`STX_B_DLLSR2]};
				drive_d.deemph_off = 1'b1;
			end
			// unused codes: safest is no de-emphasis
			default: begin
				drive_d.deemph_off = 1'b1;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			drive_o <= '0;
		end else begin
			drive_o <= drive_d;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------

	a_rate1_fields:
	assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		mode_i == stx_pkg::MODE_FS35_R1 |=>
		drive_o.drive == $past(ctrl_b_i[`STX_B_DL35R1]) &&
		drive_o.cdeemph == $past(ctrl_a_i[`STX_A_CD35R1]))
		else $error("rate1 fields not applied");

	a_rate2_fields:
	assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		mode_i == stx_pkg::MODE_FS35_R2 |=>
		drive_o.fdeemph == $past(ctrl_b_i[`STX_B_FD35R2]) &&
		drive_o.txeq == $past(ctrl_a_i[`STX_A_EQ35R2]))
		else $error("rate2 fields not applied");

	a_fs60_fields:
	assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		mode_i == stx_pkg::MODE_FS60_R2 |=>
		drive_o.drive == $past(ctrl_b_i[`STX_B_DL60R2]) &&
		drive_o.cdeemph == $past(ctrl_a_i[`STX_A_CD60R2]))
		else $error("-6 dB fields not applied");

	a_fs60_slew:
	assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		mode_i == stx_pkg::MODE_FS60_R2 |=>
		drive_o.cslew == $past(ctrl_a_i[`STX_A_CSLEW2]))
		else $error("-6 dB slew not from rate2");

	a_lowswing_fields:
	assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		mode_i == stx_pkg::MODE_LS_R2 |=>
		drive_o.txeq == 2'h0 && drive_o.fslew == $past(ctrl_a_i[`STX_A_FSLEW2]))
		else $error("low swing fields wrong");

endmodule : stx_mode_mux

/* hw/stx_tx_sel.sv */
// stx_tx_sel.sv
// tx driver setting select: lane registers, quad/port pairing, mode mux
// assumes phy state and write sources run on core_clk_i
`timescale 1ns/1ns
`include "stx_cfg.svh"

module stx_tx_sel (
	// clock and reset
	input  wire logic                  core_clk_i,
	input  wire logic                  rst_b_i,
	// configuration register port
	input  wire logic            [7:0] reg_addr_i,
	input  wire logic           [31:0] reg_wdata_i,
	input  wire logic                  reg_we_i,
	input  wire logic                  reg_re_i,
	output logic                [31:0] reg_rdata_o,
	// boot loader and management slave writes
	input  wire stx_pkg::stx_wr_s      ldr_wr_i,
	input  wire stx_pkg::stx_wr_s      smb_wr_i,
	// port phy state, one per port
	input  wire stx_pkg::stx_phy_s     port_phy_i [`STX_NQUAD],
	// settings to serdes lanes, quad*4+lane
	output stx_pkg::stx_drive_s        lane_drive_o [`STX_NLT]
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------

	stx_pkg::stx_wr_s   wr;                   // merged write
	logic         [3:0] wq;                   // write quad
	logic         [3:0] wo;                   // write offset
	logic         [2:0] sel_q  [`STX_NQUAD];  // lane select per quad
	stx_pkg::stx_phy_s  qphy   [`STX_NQUAD];  // owning port state
	stx_pkg::stx_mode_e qmode  [`STX_NQUAD];  // current mode
	logic        [31:0] a_q    [`STX_NLT];    // lane ctrl a words
	logic        [31:0] b_q    [`STX_NLT];    // lane ctrl b words
	logic               we_a   [`STX_NLT];    // lane write a
	logic               we_b   [`STX_NLT];    // lane write b
	logic         [3:0] rq;                   // read quad
	logic         [5:0] rl;                   // read lane index
	logic        [31:0] rdata_d;              // next read data

	// ----------------------------------------
	// mode decode
	// ----------------------------------------

	// phy state to field-set mode
	function automatic stx_pkg::stx_mode_e mode_of(input stx_pkg::stx_phy_s p);
		// deemph bit ignored in low swing
		if (p.low_swing) begin
			mode_of = p.rate2 ? stx_pkg::MODE_LS_R2 : stx_pkg::MODE_LS_R1;
		end else if (!p.rate2) begin
			mode_of = stx_pkg::MODE_FS35_R1;
		end else if (p.deemph_6db) begin
			mode_of = stx_pkg::MODE_FS60_R2;
		end else begin
			mode_of = stx_pkg::MODE_FS35_R2;
		end
	endfunction : mode_of

	// ----------------------------------------
	// write sources
	// ----------------------------------------

	// three writers, fixed priority
	// colliding lower writers are dropped; sources are not expected to overlap
	always_comb begin
		if (reg_we_i) begin
			wr = {1'b1, reg_addr_i, reg_wdata_i};
		end else if (ldr_wr_i.en) begin
			wr = ldr_wr_i;
		end else begin
			wr = smb_wr_i;
		end
	end

	assign wq = wr.addr[7:4];
	assign wo = wr.addr[3:0];

	// ----------------------------------------
	// quads and lanes
	// ----------------------------------------

	for (genvar gq = 0; gq < `STX_NQUAD; gq++) begin : g_quad

		// lane select, steers where writes land
		always_ff @(posedge core_clk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				sel_q[gq] <= `STX_RST_SEL;
			end else if (wr.en && wq == 4'(gq) && wo == `STX_OFS_SEL) begin
				sel_q[gq] <= wr.data[2:0];
			end
		end

		// odd quad follows merged even port
		if (gq % 2 == 1) begin : g_odd
			assign qphy[gq] = port_phy_i[gq-1].merged ? port_phy_i[gq-1] : port_phy_i[gq];
		end else begin : g_even
			assign qphy[gq] = port_phy_i[gq];
		end

		assign qmode[gq] = mode_of(qphy[gq]);

		for (genvar gl = 0; gl < `STX_NLANE; gl++) begin : g_lane
			localparam int LI = gq * `STX_NLANE + gl;

			assign we_a[LI] = wr.en && wq == 4'(gq) && wo == `STX_OFS_A &&
				(sel_q[gq][`STX_SEL_ALL] || sel_q[gq][`STX_SEL_LANE] == 2'(gl));
			assign we_b[LI] = wr.en && wq == 4'(gq) && wo == `STX_OFS_B &&
				(sel_q[gq][`STX_SEL_ALL] || sel_q[gq][`STX_SEL_LANE] == 2'(gl));

			stx_lane_regs u_regs (
				.core_clk_i (core_clk_i),
				.rst_b_i    (rst_b_i),
				.we_a_i     (we_a[LI]),
				.we_b_i     (we_b[LI]),
				.wdata_i    (wr.data),
				.ctrl_a_o   (a_q[LI]),
				.ctrl_b_o   (b_q[LI])
			);

			stx_mode_mux u_mux (
				.core_clk_i (core_clk_i),
				.rst_b_i    (rst_b_i),
				.ctrl_a_i   (a_q[LI]),
				.ctrl_b_i   (b_q[LI]),
				.mode_i     (qmode[gq]),
				.tm_i       (qphy[gq].tm),
				.drive_o    (lane_drive_o[LI])
			);
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------

	assign rq = reg_addr_i[7:4];
	assign rl = {rq, sel_q[rq][`STX_SEL_LANE]};

	// read mux, lane words seen through the select
	always_comb begin
		rdata_d = 32'h0;
		unique case (reg_addr_i[3:0])
			`STX_OFS_A:   rdata_d = a_q[rl];
			`STX_OFS_B:   rdata_d = b_q[rl];
			`STX_OFS_SEL: rdata_d = {29'h0, sel_q[rq]};
			// live mode and ownership of the quad
			`STX_OFS_STAT: begin
				rdata_d[`STX_ST_MODE]   = qmode[rq];
				rdata_d[`STX_ST_MARGIN] = (qphy[rq].tm != `STX_TM_NORMAL);
				rdata_d[`STX_ST_MERGED] = rq[0] && port_phy_i[{rq[3:1], 1'b0}].merged;
			end
			// unmapped offsets read zero
			default: rdata_d = 32'h0;
		endcase
	end

	// data stands one cycle after the strobe only
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= 32'h0;
		end else if (reg_re_i) begin
			reg_rdata_o <= rdata_d;
		end else begin
			reg_rdata_o <= 32'h0;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	// write to quad 7 word b while every lane is selected
	sequence s_wr_b7_all;
		reg_we_i && reg_addr_i == 8'h74 && sel_q[7][`STX_SEL_ALL];
	endsequence

	// write to quad 1 word a while only lane 2 is selected
	sequence s_wr_a1_l2;
		reg_we_i && reg_addr_i == 8'h10 && sel_q[1] == 3'h2;
	endsequence

	a_loader_write:
	assert property (ldr_wr_i.en && !reg_we_i && ldr_wr_i.addr == 8'h34 &&
		sel_q[3] == 3'h0 |=> b_q[12] == $past(ldr_wr_i.data))
		else $error("loader write lost");

	a_margin_all:
	assert property (port_phy_i[7].tm != `STX_TM_NORMAL && !port_phy_i[6].merged |=>
		lane_drive_o[31].margin_on && lane_drive_o[31].margin == $past(port_phy_i[7].tm))
		else $error("margin not applied to quad 7");

	a_merged_margin:
	assert property (port_phy_i[6].merged |=>
		lane_drive_o[28].margin == $past(port_phy_i[6].tm))
		else $error("merged quad 7 not following port 6");

	a_x4_own_quad:
	assert property (!port_phy_i[6].merged |=>
		lane_drive_o[28].margin == $past(port_phy_i[7].tm))
		else $error("x4 quad 7 not following port 7");

	a_lane_select:
	assert property (s_wr_a1_l2 |=>
		a_q[6] == ($past(reg_wdata_i) & `STX_MASK_A) && a_q[5] == $past(a_q[5]))
		else $error("lane select write misplaced");

	a_reset_default:
	assert property ($rose(rst_b_i) |-> a_q[0] == `STX_RST_A && b_q[63] == `STX_RST_B)
		else $error("lane defaults wrong after reset");

	a_mode_follow:
	assert property ($rose(port_phy_i[1].rate2) && !port_phy_i[1].low_swing &&
		!port_phy_i[1].deemph_6db && !port_phy_i[0].merged |=>
		lane_drive_o[4].drive == $past(b_q[4][`STX_B_DL35R2]))
		else $error("rate change did not switch fields");

	a_write_immediate:
	assert property (s_wr_b7_all ##1 qmode[7] == stx_pkg::MODE_FS35_R1 |=>
		lane_drive_o[29].drive == $past(reg_wdata_i[`STX_B_DL35R1], 2))
		else $error("write not applied in two cycles");

	a_lowswing_flat:
	assert property (port_phy_i[1].low_swing && !port_phy_i[0].merged |=>
		lane_drive_o[4].deemph_off && lane_drive_o[4].cdeemph == 2'h0)
		else $error("low swing kept de-emphasis");

endmodule : stx_tx_sel

/* inc/stx_cfg.svh */
// stx_cfg.svh
// offsets, field ranges, reset values and sizes of the tx setting select block
// assumes inclusion by its bare name from design and bench files
`ifndef STX_CFG_SVH
`define STX_CFG_SVH

// ----------------------------------------
// sizes
// ----------------------------------------
`define STX_NQUAD     16
`define STX_NLANE     4
`define STX_NLT       64
`define STX_TM_NORMAL 3'h0

// ----------------------------------------
// register offsets inside one quad window
// ----------------------------------------
`define STX_OFS_A     4'h0
`define STX_OFS_B     4'h4
`define STX_OFS_SEL   4'h8
`define STX_OFS_STAT  4'hC

// ----------------------------------------
// lane_tx_ctrl_a fields
// ----------------------------------------
`define STX_A_CSLEW1  1:0
`define STX_A_FSLEW1  3:2
`define STX_A_CSLEW2  5:4
`define STX_A_FSLEW2  7:6
`define STX_A_EQ35R1  9:8
`define STX_A_CD35R1  11:10
`define STX_A_EQ35R2  13:12
`define STX_A_CD35R2  15:14
`define STX_A_EQ60R2  17:16
`define STX_A_CD60R2  19:18
`define STX_MASK_A    32'h000FFFFF
`define STX_RST_A     32'h00095E02

// ----------------------------------------
// lane_tx_ctrl_b fields
// ----------------------------------------
`define STX_B_DL35R1  4:0
`define STX_B_FD35R1  7:5
`define STX_B_DL35R2  12:8
`define STX_B_FD35R2  15:13
`define STX_B_DL60R2  20:16
`define STX_B_FD60R2  23:21
`define STX_B_DLLSR1  27:24
`define STX_B_DLLSR2  31:28
`define STX_RST_B     32'hEE9C7C7C

// ----------------------------------------
// serdes_lane_select_reg and status fields
// ----------------------------------------
`define STX_SEL_LANE  1:0
`define STX_SEL_ALL   2
`define STX_RST_SEL   3'h0
`define STX_ST_MODE   2:0
`define STX_ST_MARGIN 3
`define STX_ST_MERGED 4

`endif

/* inc/stx_pkg.sv */
// stx_pkg.sv
// types shared by the tx setting select design files
// assumes its widths agree with the field ranges in stx_cfg.svh
package stx_pkg;

	// phy operating mode of one quad
	typedef enum logic [2:0] {
		MODE_FS35_R1 = 3'b000,
		MODE_FS35_R2 = 3'b001,
		MODE_FS60_R2 = 3'b010,
		MODE_LS_R1   = 3'b011,
		MODE_LS_R2   = 3'b100
	} stx_mode_e;

	// per-port phy state and link control 2 bits
	typedef struct packed {
		logic [2:0] tm;          // tx_margin_field
		logic       merged;      // x8, valid on even port
		logic       low_swing;   // low-swing link
		logic       rate2;       // 5.0 GT/s
		logic       deemph_6db;  // selectable de-emphasis
	} stx_phy_s;

	// settings driven into one serdes lane
	typedef struct packed {
		logic       margin_on;   // voltage from margin
		logic [2:0] margin;      // margin value
		logic [4:0] drive;       // drive level
		logic [1:0] cdeemph;     // coarse de-emphasis
		logic [1:0] txeq;        // tx equalization
		logic [2:0] fdeemph;     // fine de-emphasis
		logic [1:0] cslew;       // coarse slew
		logic [1:0] fslew;       // fine slew
		logic       deemph_off;  // 0 dB forced
	} stx_drive_s;

	// one register write from any source
	typedef struct packed {
		logic        en;
		logic [7:0]  addr;
		logic [31:0] data;
	} stx_wr_s;

endpackage : stx_pkg

/* testbench/stx_phy_model.sv */
// stx_phy_model.sv
// behavioural port phy state of the sixteen ports that feed the select block
// assumes the bench requests one port update per edge on core_clk_i
`timescale 1ns/1ns
`include "stx_cfg.svh"

module stx_phy_model (
	// clock and reset
	input  wire logic              core_clk_i,
	input  wire logic              rst_b_i,
	// bench requests
	input  wire logic              set_i,
	input  wire logic        [3:0] port_i,
	input  wire stx_pkg::stx_phy_s val_i,
	// phy state per port
	output stx_pkg::stx_phy_s      port_phy_o [`STX_NQUAD]
);
	// ------
	// phy state
	// ------
	// state changes just after an edge, like the real link logic
	// merge on even
	// odd ports never claim a merge: only an even port owns an x8 pair
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (int p = 0; p < `STX_NQUAD; p++)
				port_phy_o[p] <= '0;
		end else if (set_i) begin
			port_phy_o[port_i] <= {val_i.tm, val_i.merged & ~port_i[0], val_i.low_swing,
				val_i.rate2, val_i.deemph_6db};
		end
	end
endmodule : stx_phy_model

/* testbench/stx_tx_sel_tb.sv */
// stx_tx_sel_tb.sv
// self-checking bench of the tx setting select block
// assumes stx_pkg and stx_cfg.svh; phy state comes from stx_phy_model
`timescale 1ns/1ns
`include "stx_cfg.svh"

module stx_tx_sel_tb;
	// ------
	// signals
	// ------
	logic                core_clk = 1'b0;     // 10 MHz
	logic                rst_b    = 1'b0;     // held low at start
	logic [7:0]          reg_addr = 8'h00;
	logic [31:0]         reg_wdata = 32'h0;
	logic                reg_we   = 1'b0;
	logic                reg_re   = 1'b0;
	logic [31:0]         reg_rdata;
	stx_pkg::stx_wr_s    ldr_wr   = '0;       // boot loader source
	stx_pkg::stx_wr_s    smb_wr   = '0;       // management source
	logic                set_q    = 1'b0;     // phy update request
	logic [3:0]          port_q   = 4'h0;
	stx_pkg::stx_phy_s   val_q    = '0;
	stx_pkg::stx_phy_s   phy [`STX_NQUAD];
	stx_pkg::stx_drive_s lane_drv [`STX_NLT];
	logic                re_d     = 1'b0;     // read data due
	logic                look     = 1'b0;     // lane notes due
	logic [31:0]         seed     = 32'h0C6E;
	logic [31:0]         sa [`STX_NLT];       // shadow ctrl_a
	logic [31:0]         sb [`STX_NLT];       // shadow ctrl_b
	logic [2:0]          ssel [`STX_NQUAD];   // shadow select
	logic [31:0]         rd_q [$];            // read notes
	stx_pkg::stx_drive_s ln_q [$];            // lane notes
	int                  bad_count = 0;
	int                  tests_run = 0;

	always #50 core_clk = ~core_clk;

	stx_tx_sel DUT (
		.core_clk_i  (core_clk),
		.rst_b_i     (rst_b),
		.reg_addr_i  (reg_addr),
		.reg_wdata_i (reg_wdata),
		.reg_we_i    (reg_we),
		.reg_re_i    (reg_re),
		.reg_rdata_o (reg_rdata),
		.ldr_wr_i    (ldr_wr),
		.smb_wr_i    (smb_wr),
		.port_phy_i  (phy),
		.lane_drive_o(lane_drv)
	);

	stx_phy_model PHY (
		.core_clk_i(core_clk),
		.rst_b_i   (rst_b),
		.set_i     (set_q),
		.port_i    (port_q),
		.val_i     (val_q),
		.port_phy_o(phy)
	);

	// ------
	// helpers
	// ------
	function automatic logic [31:0] rand32();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rand32

	function automatic void sh_wr(logic [7:0] ad, logic [31:0] d);
		int q;
		q = int'(ad[7:4]);
		if (ad[3:0] == `STX_OFS_SEL)
			ssel[q] = d[2:0];
		for (int l = 0; l < 4; l++)
			if (ssel[q][`STX_SEL_ALL] || l == int'(ssel[q][`STX_SEL_LANE])) begin
				if (ad[3:0] == `STX_OFS_A)
					sa[q*4+l] = d & `STX_MASK_A;
				if (ad[3:0] == `STX_OFS_B)
					sb[q*4+l] = d;
			end
	endfunction : sh_wr

	function automatic logic [31:0] exp_rd(logic [7:0] ad);
		int                n;
		int                q;
		logic              own;
		stx_pkg::stx_phy_s p;
		logic [2:0]        m;
		q = int'(ad[7:4]);
		n = q * 4 + int'(ssel[q][`STX_SEL_LANE]);
		own = (q % 2 == 1) ? phy[q-1].merged : 1'b0;
		p = own ? phy[q-1] : phy[q];
		if (p.low_swing)
			m = p.rate2 ? stx_pkg::MODE_LS_R2 : stx_pkg::MODE_LS_R1;
		else if (!p.rate2)
			m = stx_pkg::MODE_FS35_R1;
		else
			m = p.deemph_6db ? stx_pkg::MODE_FS60_R2 : stx_pkg::MODE_FS35_R2;
		case (ad[3:0])
			`STX_OFS_A:    return sa[n];
			`STX_OFS_B:    return sb[n];
			`STX_OFS_SEL:  return {29'h0, ssel[q]};
			`STX_OFS_STAT: return {27'h0, own, p.tm != 3'h0, m};
			default:       return 32'h0;   // unmapped reads zero
		endcase
	endfunction : exp_rd

	function automatic stx_pkg::stx_drive_s exp_drv(int n);
		stx_pkg::stx_phy_s   p;
		stx_pkg::stx_drive_s r;
		logic [31:0]         a;
		logic [31:0]         b;
		a = sa[n];
		b = sb[n];
		p = phy[n/4];
		if ((n / 4) % 2 == 1 && phy[n/4-1].merged)
			p = phy[n/4-1];
		r = '0;
		r.margin_on = (p.tm != 3'h0);
		r.margin = p.tm;
		r.cslew = p.rate2 ? a[`STX_A_CSLEW2] : a[`STX_A_CSLEW1];
		r.fslew = p.rate2 ? a[`STX_A_FSLEW2] : a[`STX_A_FSLEW1];
		if (p.low_swing) begin
			r.deemph_off = 1'b1;
			r.drive = {1'b0, p.rate2 ? b[`STX_B_DLLSR2] : b[`STX_B_DLLSR1]};
		end else if (!p.rate2) begin   // rate1 set
			r.drive = b[`STX_B_DL35R1];
			r.fdeemph = b[`STX_B_FD35R1];
			r.cdeemph = a[`STX_A_CD35R1];
			r.txeq = a[`STX_A_EQ35R1];
		end else if (!p.deemph_6db) begin   // rate2 set
			r.drive = b[`STX_B_DL35R2];
			r.fdeemph = b[`STX_B_FD35R2];
			r.cdeemph = a[`STX_A_CD35R2];
			r.txeq = a[`STX_A_EQ35R2];
		end else begin   // six dB set
			r.drive = b[`STX_B_DL60R2];
			r.fdeemph = b[`STX_B_FD60R2];
			r.cdeemph = a[`STX_A_CD60R2];
			r.txeq = a[`STX_A_EQ60R2];
		end
		return r;
	endfunction : exp_drv

	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// ------
	// drivers, entered just after a rising edge
	// ------
	// three write sources
	// winner is config, then loader, then management
	task automatic wr3(logic [2:0] en, logic [7:0] ad, logic [31:0] d0, d1, d2);
		reg_we <= en[0];
		reg_re <= 1'b0;
		reg_addr <= ad;
		reg_wdata <= d0;
		ldr_wr <= {en[1], ad, d1};
		smb_wr <= {en[2], ad, d2};
		if (en != 3'b000)
			sh_wr(ad, en[0] ? d0 : (en[1] ? d1 : d2));
		@(posedge core_clk);
	endtask : wr3

	task automatic wr(logic [7:0] ad, logic [31:0] d);
		wr3(3'b001, ad, d, 32'h0, 32'h0);
	endtask : wr

	task automatic rd(logic [7:0] ad);
		reg_we <= 1'b0;
		reg_re <= 1'b1;
		reg_addr <= ad;
		ldr_wr <= '0;
		smb_wr <= '0;
		rd_q.push_back(exp_rd(ad));
		@(posedge core_clk);
	endtask : rd

	task automatic phy_set(logic [3:0] p, stx_pkg::stx_phy_s v);
		// strobes stay one cycle even when a read came just before
		reg_we <= 1'b0;
		reg_re <= 1'b0;
		set_q <= 1'b1;
		port_q <= p;
		val_q <= v;
		@(posedge core_clk);
	endtask : phy_set

	// idle, let writes land two cycles, then note all 64 lanes
	task automatic settle();
		wr3(3'b000, 8'h00, 32'h0, 32'h0, 32'h0);
		set_q <= 1'b0;
		repeat (2) @(posedge core_clk);
		for (int n = 0; n < `STX_NLT; n++)
			ln_q.push_back(exp_drv(n));
		look <= 1'b1;
		@(posedge core_clk);
		look <= 1'b0;
	endtask : settle

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish

	// ------
	// watcher: oldest note against what appears
	// ------
	always @(posedge core_clk) begin
		re_d <= reg_re;
	end

	always @(negedge core_clk) begin
		if (re_d)
			check("rdata", reg_rdata, rd_q.pop_front());
		if (look)
			for (int n = 0; n < `STX_NLT; n++)
				check("lane", {11'h0, lane_drv[n]}, {11'h0, ln_q.pop_front()});
	end

	// ------
	// main sequence
	// ------
	initial begin
		for (int n = 0; n < `STX_NLT; n++) begin
			sa[n] = `STX_RST_A;
			sb[n] = `STX_RST_B;
		end
		for (int q = 0; q < `STX_NQUAD; q++)
			ssel[q] = 3'h0;
		repeat (6) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		for (int q = 0; q < 16; q += 15) begin
			rd({q[3:0], `STX_OFS_A});
			rd({q[3:0], `STX_OFS_B});
			rd({q[3:0], `STX_OFS_SEL});
			rd({q[3:0], 4'h2});
		end
		settle();
		// lane writes
		// quad 1 hits lane 2 only, quad 7 all four lanes
		for (int q = 1; q < 8; q += 6) begin
			wr({q[3:0], `STX_OFS_SEL}, {29'h0, q[2], 2'h2});
			wr({q[3:0], `STX_OFS_A}, rand32());
			wr({q[3:0], `STX_OFS_B}, rand32());
			rd({q[3:0], `STX_OFS_A});
			rd({q[3:0], `STX_OFS_B});
		end
		settle();
		// every mode
		// all swing, rate and de-emphasis combinations on port 1
		for (int m = 0; m < 8; m++) begin
			phy_set(4'h1, {3'h0, 1'b0, m[2:0]});
			settle();
			rd(8'h1C);
		end
		// margin values
		// margin is only moved while the bench is otherwise quiet
		for (int t = 0; t < 8; t++) begin
			phy_set(4'h7, {t[2:0], 4'b0010});
			settle();
			rd(8'h7C);
		end
		phy_set(4'h6, {3'h2, 4'b1010});
		phy_set(4'h7, {3'h0, 4'b0100});
		settle();
		phy_set(4'h6, {3'h0, 4'b1011});
		settle();
		rd(8'h7C);
		phy_set(4'h6, '0);
		settle();
		rd(8'h7C);
		wr3(3'b111, 8'h30, rand32(), rand32(), rand32());
		rd(8'h30);
		wr3(3'b110, 8'h34, rand32(), rand32(), rand32());
		rd(8'h34);
		wr3(3'b100, 8'h38, rand32(), rand32(), rand32());
		rd(8'h38);
		rd(8'h30);
		wr(8'h3D, rand32());
		rd(8'h3D);
		settle();
		tally_and_finish();
	end

	// watchdog: the sequence needs well under 400 cycles
	initial begin
		repeat (2000) @(posedge core_clk);
		bad_count++;
		$display("Error watchdog expired");
		tally_and_finish();
	end
endmodule : stx_tx_sel_tb
